// [hdl/dsap_pkg.sv]
package dsap_pkg;

   // Register byte offsets on the Wishbone slave
   localparam logic [7:0] OFS_CR = 8'h00;
   localparam logic [7:0] OFS_SR = 8'h04;
   localparam logic [7:0] OFS_ADDR = 8'h08;
   localparam logic [7:0] OFS_LEN = 8'h0C;
   localparam logic [7:0] OFS_DATA = 8'h10;

   // Command bits of the control register (write one to act)
   localparam int CR_UPR = 0;
   localparam int CHECKSUM_START_CMD = 1;
   localparam int CR_OFF = 2;
   localparam int CR_ON = 3;

   // Status register field positions
   localparam int SR_DONE = 0;
   localparam int BUS_FAULT_FLAG = 1;
   localparam int SR_FAIL = 2;
   localparam int SR_EN = 3;
   localparam int PORT_STATE_FIELD = 4;
   localparam int SR_PROT = 8;
   localparam int SR_START = 9;

   // Values after reset and checksum presets
   localparam logic [31:0] ADDR_RST = 32'h0000_0000;
   localparam logic [31:0] LEN_RST = 32'h0000_0000;
   localparam logic [31:0] DATA_RST = 32'h0000_0000;
   localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
   localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;
   localparam logic [31:0] WORD_STEP = 32'h0000_0004;
   localparam logic [31:0] FLASH_BASE_DEF = 32'h0000_0000;
   localparam logic [31:0] FLASH_BYTES_DEF = 32'h0001_0000;
   localparam logic [31:0] UPAGE_BASE_DEF = 32'h0080_0000;
   localparam logic [31:0] UPAGE_BYTES_DEF = 32'h0000_0200;

   // Pad indices of the pins the test port takes over
   localparam int PAD_TMS = 0;
   localparam int PAD_TDO = 1;
   localparam int PAD_TDI = 2;
   localparam int PAD_TCK = 3;

   // Engine state, also shown in the port state field
   typedef enum logic [2:0] {
      DSAP_IDLE = 3'h0,
      DSAP_UPR = 3'h1,
      DSAP_CRC = 3'h2
   } dsap_op_e;

   // Test access state machine
   typedef enum logic [3:0] {
      DSAP_TLR = 4'h0, DSAP_RTI = 4'h1, DSAP_SDRS = 4'h2, DSAP_CDR = 4'h3,
      DSAP_SDR = 4'h4, DSAP_E1DR = 4'h5, DSAP_PDR = 4'h6, DSAP_E2DR = 4'h7,
      DSAP_UDR = 4'h8, DSAP_SIRS = 4'h9, DSAP_CIR = 4'hA, DSAP_SIR = 4'hB,
      DSAP_E1IR = 4'hC, DSAP_PIR = 4'hD, DSAP_E2IR = 4'hE, DSAP_UIR = 4'hF
   } dsap_tap_e;

   // Pin levels of the serial test port
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
      logic en;
   } dsap_link_s;

   // Next test state for a given mode select level
   function automatic dsap_tap_e dsap_tap_next(input dsap_tap_e s, input logic m);
      unique case (s)
         DSAP_TLR: dsap_tap_next = m ? DSAP_TLR : DSAP_RTI;
         DSAP_RTI: dsap_tap_next = m ? DSAP_SDRS : DSAP_RTI;
         DSAP_SDRS: dsap_tap_next = m ? DSAP_SIRS : DSAP_CDR;
         DSAP_CDR: dsap_tap_next = m ? DSAP_E1DR : DSAP_SDR;
         DSAP_SDR: dsap_tap_next = m ? DSAP_E1DR : DSAP_SDR;
         DSAP_E1DR: dsap_tap_next = m ? DSAP_UDR : DSAP_PDR;
         DSAP_PDR: dsap_tap_next = m ? DSAP_E2DR : DSAP_PDR;
         DSAP_E2DR: dsap_tap_next = m ? DSAP_UDR : DSAP_SDR;
         DSAP_UDR: dsap_tap_next = m ? DSAP_SDRS : DSAP_RTI;
         DSAP_SIRS: dsap_tap_next = m ? DSAP_TLR : DSAP_CIR;
         DSAP_CIR: dsap_tap_next = m ? DSAP_E1IR : DSAP_SIR;
         DSAP_SIR: dsap_tap_next = m ? DSAP_E1IR : DSAP_SIR;
         DSAP_E1IR: dsap_tap_next = m ? DSAP_UIR : DSAP_PIR;
         DSAP_PIR: dsap_tap_next = m ? DSAP_E2IR : DSAP_PIR;
         DSAP_E2IR: dsap_tap_next = m ? DSAP_UIR : DSAP_SIR;
         DSAP_UIR: dsap_tap_next = m ? DSAP_SDRS : DSAP_RTI;
      endcase
   endfunction

endpackage

// [hdl/dsap_crc_word.sv]
`timescale 1ns/1ps
`default_nettype none

// One 32-bit word folded into a reflected checksum, bit 0 first
module dsap_crc_word (
   // Running value and new word
   input wire logic [31:0] crc_in,
   input wire logic [31:0] data_in,
   // Updated value
   output logic [31:0] crc_out
);

   // Chain of partial results, one stage per data bit
   logic [31:0] stage [0:32];

   assign stage[0] = crc_in;

   genvar i;
   generate
      for (i = 0; i < 32; i++) begin : g_bit
         logic fb;
         assign fb = stage[i][0] ^ data_in[i];
         assign stage[i+1] = {1'b0, stage[i][31:1]} ^ (fb ? dsap_pkg::CRC_POLY : 32'h0000_0000);
      end
   endgenerate

   assign crc_out = stage[32];

endmodule

`default_nettype wire

// [hdl/dsap_top.sv]
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Enabled test port owns its pins
// - Protected state blocks memory access port
// - Chip erase alone reopens memory access port
// - Reported protection changes only through reset
// - Shift registers move bit zero first
// - Status bits report error, busy, startup, protection
// - Partial data register shifts are accepted
// - Instruction shift shows protection and startup
// - User page readable while protected
// - Offset then command starts user page read
// - State field shows user page read
// - Read word in data in the same cycle as done
// - Offset bits beyond page are dropped
// - Offset advances one word per read
// - Checksum uses reflected standard polynomial
// - Start bit runs; off cancels, on restores
// - Protected checksum forced over whole flash
// - Done with bus fault and fail flags
module dsap_top #(
   parameter logic [31:0] FLASH_BASE = dsap_pkg::FLASH_BASE_DEF,
   parameter logic [31:0] FLASH_BYTES = dsap_pkg::FLASH_BYTES_DEF,
   parameter logic [31:0] UPAGE_BASE = dsap_pkg::UPAGE_BASE_DEF,
   parameter logic [31:0] UPAGE_BYTES = dsap_pkg::UPAGE_BYTES_DEF
) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // Wishbone slave
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic wb_ack_out,
   output logic [31:0] wb_dat_out,
   // Serial test port pins
   input wire logic port_en_in,
   input wire logic tck_in,
   input wire logic tms_in,
   input wire logic tdi_in,
   // Pad drive, mux request in and final drive out
   input wire logic [3:0] mux_do_in,
   input wire logic [3:0] mux_oe_in,
   output logic [3:0] pad_do_out,
   output logic [3:0] pad_oe_out,
   // Protection and status from the flash controller
   input wire logic sec_bit_in,
   input wire logic erase_done_in,
   input wire logic startup_done_in,
   output logic prot_out,
   // Memory access port gate
   input wire logic map_req_in,
   output logic map_req_out,
   // System bus reads
   output logic mem_req_out,
   output logic [31:0] mem_addr_out,
   input wire logic mem_ack_in,
   input wire logic mem_err_in,
   input wire logic [31:0] mem_rdata_in
);

   // Byte-lane merge for register writes
   function automatic logic [31:0] dsap_merge(input logic [31:0] o, input logic [31:0] n,
                                             input logic [3:0] s);
      for (int k = 0; k < 4; k++) begin
         dsap_merge[8*k +: 8] = s[k] ? n[8*k +: 8] : o[8*k +: 8];
      end
   endfunction

   // Pin synchronisers; stage one is read only by stage two
   dsap_pkg::dsap_link_s link_s1_reg, link_s2_reg, link_now;
   logic tck_d_reg;
   logic tck_rise, tck_fall;

   assign link_now = '{tck: tck_in, tms: tms_in, tdi: tdi_in, en: port_en_in};

   // Two flops per pin, plus a delayed clock level for edges
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         link_s1_reg <= '0;
         link_s2_reg <= '0;
         tck_d_reg <= 1'b0;
      end else begin
         link_s1_reg <= link_now;
         link_s2_reg <= link_s1_reg;
         tck_d_reg <= link_s2_reg.tck;
      end
   end

   assign tck_rise = link_s2_reg.tck & ~tck_d_reg;
   assign tck_fall = ~link_s2_reg.tck & tck_d_reg;

   // Protection capture, lock and memory access gate
   logic cap_done_reg, cap_done_next;
   logic prot_reg, prot_next;
   logic lock_reg, lock_next;
   logic map_reg, map_next;

   // Protection is sampled once after reset; erase only lifts the lock
   always_comb begin
      cap_done_next = 1'b1;
      prot_next = prot_reg;
      lock_next = lock_reg;
      if (!cap_done_reg) begin
         prot_next = sec_bit_in;
         lock_next = sec_bit_in;
      end else if (erase_done_in) begin
         lock_next = 1'b0;
      end
      map_next = map_req_in & ~lock_reg;
   end

   // Locked until the first sample, so nothing leaks through at start
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         cap_done_reg <= 1'b0;
         prot_reg <= 1'b1;
         lock_reg <= 1'b1;
         map_reg <= 1'b0;
      end else begin
         cap_done_reg <= cap_done_next;
         prot_reg <= prot_next;
         lock_reg <= lock_next;
         map_reg <= map_next;
      end
   end

   // Engine state, declared early for the status capture
   dsap_pkg::dsap_op_e op_reg, op_next;
   logic done_reg, done_next;
   logic berr_reg, berr_next;
   logic fail_reg, fail_next;
   logic en_reg, en_next;

   // Test access machine and shift registers
   dsap_pkg::dsap_tap_e tap_reg, tap_next;
   logic [3:0] ir_sh_reg, ir_sh_next;
   logic [31:0] dr_sh_reg, dr_sh_next;
   logic tdo_reg, tdo_next;
   logic [3:0] pdo_reg, pdo_next, poe_reg, poe_next;
   logic shifting;

   assign shifting = (tap_reg == dsap_pkg::DSAP_SDR) || (tap_reg == dsap_pkg::DSAP_SIR);

   // Work happens on the sampled rising edge, output change on the falling one
   always_comb begin
      tap_next = tap_reg;
      ir_sh_next = ir_sh_reg;
      dr_sh_next = dr_sh_reg;
      tdo_next = tdo_reg;
      if (!link_s2_reg.en) begin
         tap_next = dsap_pkg::DSAP_TLR;
      end else if (tck_rise) begin
         tap_next = dsap_pkg::dsap_tap_next(tap_reg, link_s2_reg.tms);
         unique case (tap_reg)
            dsap_pkg::DSAP_CIR: ir_sh_next = {prot_reg, 2'b00, startup_done_in};
            dsap_pkg::DSAP_SIR: ir_sh_next = {link_s2_reg.tdi, ir_sh_reg[3:1]};
            dsap_pkg::DSAP_CDR: dr_sh_next = {28'h000_0000, prot_reg, startup_done_in,
                                              op_reg != dsap_pkg::DSAP_IDLE,
                                              berr_reg | fail_reg};
            // any number of shifts is fine
            dsap_pkg::DSAP_SDR: dr_sh_next = {link_s2_reg.tdi, dr_sh_reg[31:1]};
            default: ;
         endcase
      end else if (tck_fall && shifting) begin
         tdo_next = (tap_reg == dsap_pkg::DSAP_SIR) ? ir_sh_reg[0] : dr_sh_reg[0];
      end
      pdo_next = mux_do_in;
      poe_next = mux_oe_in;
      if (link_s2_reg.en) begin
         poe_next = 4'h0;
         poe_next[dsap_pkg::PAD_TDO] = shifting;
         pdo_next[dsap_pkg::PAD_TDO] = tdo_next;
      end
   end

   // Registers of the test access side
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         tap_reg <= dsap_pkg::DSAP_TLR;
         ir_sh_reg <= 4'h0;
         dr_sh_reg <= 32'h0000_0000;
         tdo_reg <= 1'b0;
         pdo_reg <= 4'h0;
         poe_reg <= 4'h0;
      end else begin
         tap_reg <= tap_next;
         ir_sh_reg <= ir_sh_next;
         dr_sh_reg <= dr_sh_next;
         tdo_reg <= tdo_next;
         pdo_reg <= pdo_next;
         poe_reg <= poe_next;
      end
   end

   // Wishbone slave: ack one cycle after the strobe, write at that ack edge
   logic ack_reg, ack_next;
   logic [31:0] rdat_reg, rdat_next;
   logic [31:0] addr_reg, addr_next, len_reg, len_next, data_reg, data_next;
   logic mreq_reg, mreq_next;
   logic [31:0] maddr_reg, maddr_next;
   logic [31:0] crc_word;
   logic wr, cr_wr;
   logic [31:0] sr_val;

   assign wr = wb_cyc_in & wb_stb_in & wb_we_in & ack_reg;
   assign cr_wr = wr & (wb_adr_in == dsap_pkg::OFS_CR) & wb_sel_in[0];

   // Status word as software reads it
   always_comb begin
      sr_val = 32'h0000_0000;
      sr_val[dsap_pkg::SR_DONE] = done_reg;
      sr_val[dsap_pkg::BUS_FAULT_FLAG] = berr_reg;
      sr_val[dsap_pkg::SR_FAIL] = fail_reg;
      sr_val[dsap_pkg::SR_EN] = en_reg;
      sr_val[dsap_pkg::PORT_STATE_FIELD +: 3] = op_reg;
      sr_val[dsap_pkg::SR_PROT] = prot_reg;
      sr_val[dsap_pkg::SR_START] = startup_done_in;
   end

   // Read data is taken when ack rises; unmapped and command reads give zero
   always_comb begin
      ack_next = wb_cyc_in & wb_stb_in & ~ack_reg;
      rdat_next = rdat_reg;
      if (ack_next) begin
         unique case (wb_adr_in)
            dsap_pkg::OFS_SR: rdat_next = sr_val;
            dsap_pkg::OFS_ADDR: rdat_next = addr_reg;
            dsap_pkg::OFS_LEN: rdat_next = len_reg;
            dsap_pkg::OFS_DATA: rdat_next = data_reg;
            default: rdat_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         ack_reg <= 1'b0;
         rdat_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= ack_next;
         rdat_reg <= rdat_next;
      end
   end

   // Checksum of the incoming word against the running value
   dsap_crc_word u_crc (
      .crc_in(data_reg),
      .data_in(mem_rdata_in),
      .crc_out(crc_word)
   );

   // Operation engine: one bus read at a time, one idle cycle between reads
   always_comb begin
      op_next = op_reg;
      done_next = done_reg;
      berr_next = berr_reg;
      fail_next = fail_reg;
      en_next = en_reg;
      addr_next = addr_reg;
      len_next = len_reg;
      data_next = data_reg;
      mreq_next = mreq_reg;
      maddr_next = maddr_reg;
      // Register loads only while idle, so a run cannot be disturbed
      if (wr && op_reg == dsap_pkg::DSAP_IDLE) begin
         if (wb_adr_in == dsap_pkg::OFS_ADDR) addr_next = dsap_merge(addr_reg, wb_dat_in, wb_sel_in);
         if (wb_adr_in == dsap_pkg::OFS_LEN) len_next = dsap_merge(len_reg, wb_dat_in, wb_sel_in);
         if (wb_adr_in == dsap_pkg::OFS_DATA) data_next = dsap_merge(data_reg, wb_dat_in, wb_sel_in);
      end
      if (mreq_reg && mem_ack_in) begin
         mreq_next = 1'b0;
         if (mem_err_in) begin
            berr_next = 1'b1;
            done_next = 1'b1;
            op_next = dsap_pkg::DSAP_IDLE;
         end else if (op_reg == dsap_pkg::DSAP_UPR) begin
            data_next = mem_rdata_in;
            addr_next = addr_reg + dsap_pkg::WORD_STEP;
            done_next = 1'b1;
            op_next = dsap_pkg::DSAP_IDLE;
         end else begin
            data_next = crc_word;
            addr_next = addr_reg + dsap_pkg::WORD_STEP;
            len_next = len_reg - dsap_pkg::WORD_STEP;
            if (len_reg == dsap_pkg::WORD_STEP) begin
               done_next = 1'b1;
               op_next = dsap_pkg::DSAP_IDLE;
            end
         end
      end else if (!mreq_reg && op_reg == dsap_pkg::DSAP_UPR) begin
         mreq_next = 1'b1;
         maddr_next = UPAGE_BASE + (addr_reg & (UPAGE_BYTES - 32'h0000_0001) & ~32'h0000_0003);
      end else if (!mreq_reg && op_reg == dsap_pkg::DSAP_CRC) begin
         mreq_next = 1'b1;
         maddr_next = addr_reg;
      end
      if (cr_wr && wb_dat_in[dsap_pkg::CR_OFF]) begin
         op_next = dsap_pkg::DSAP_IDLE;
         {done_next, berr_next, fail_next, en_next, mreq_next} = 5'h00;
         addr_next = dsap_pkg::ADDR_RST;
         len_next = dsap_pkg::LEN_RST;
         data_next = dsap_pkg::DATA_RST;
      end else if (cr_wr) begin
         if (wb_dat_in[dsap_pkg::CR_ON]) en_next = 1'b1;
         if (en_reg && op_reg == dsap_pkg::DSAP_IDLE) begin
            if (wb_dat_in[dsap_pkg::CR_UPR]) begin
               op_next = dsap_pkg::DSAP_UPR;
               {done_next, berr_next, fail_next} = 3'h0;
            end else if (wb_dat_in[dsap_pkg::CHECKSUM_START_CMD]) begin
               {done_next, berr_next, fail_next} = 3'h0;
               op_next = dsap_pkg::DSAP_CRC;
               if (lock_reg) begin
                  addr_next = FLASH_BASE;
                  len_next = FLASH_BYTES;
                  data_next = dsap_pkg::CRC_INIT;
               end else if ((addr_reg[1:0] | len_reg[1:0]) != 2'h0) begin
                  fail_next = 1'b1;
                  done_next = 1'b1;
                  op_next = dsap_pkg::DSAP_IDLE;
               end else if (len_reg == 32'h0000_0000) begin
                  done_next = 1'b1;
                  op_next = dsap_pkg::DSAP_IDLE;
               end
            end
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         op_reg <= dsap_pkg::DSAP_IDLE;
         {done_reg, berr_reg, fail_reg, mreq_reg} <= 4'h0;
         en_reg <= 1'b1;
         addr_reg <= dsap_pkg::ADDR_RST;
         len_reg <= dsap_pkg::LEN_RST;
         data_reg <= dsap_pkg::DATA_RST;
         maddr_reg <= 32'h0000_0000;
      end else begin
         op_reg <= op_next;
         {done_reg, berr_reg, fail_reg, mreq_reg} <= {done_next, berr_next, fail_next, mreq_next};
         en_reg <= en_next;
         addr_reg <= addr_next;
         len_reg <= len_next;
         data_reg <= data_next;
         maddr_reg <= maddr_next;
      end
   end

   // Outputs, all straight from flops
   assign wb_ack_out = ack_reg;
   assign wb_dat_out = rdat_reg;
   assign pad_do_out = pdo_reg;
   assign pad_oe_out = poe_reg;
   assign prot_out = prot_reg;
   assign map_req_out = map_reg;
   assign mem_req_out = mreq_reg;
   assign mem_addr_out = maddr_reg;

   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);

   pin_own_a: assert property (link_s2_reg.en |=> pad_oe_out[dsap_pkg::PAD_TMS] == 1'b0
      && pad_oe_out[dsap_pkg::PAD_TCK] == 1'b0) else $error("test pins not owned");
   map_block_a: assert property (lock_reg |=> !map_req_out)
      else $error("memory access passed while locked");
   erase_open_a: assert property ($fell(lock_reg) && $past(cap_done_reg)
      |-> $past(erase_done_in)) else $error("lock lifted without erase");
   prot_hold_a: assert property (cap_done_reg && $past(cap_done_reg) |-> $stable(prot_reg))
      else $error("reported protection changed without reset");
   tdo_lsb_a: assert property (tck_fall && tap_reg == dsap_pkg::DSAP_SDR && link_s2_reg.en
      |=> pad_do_out[dsap_pkg::PAD_TDO] == $past(dr_sh_reg[0])) else $error("wrong bit order");
   ir_pat_a: assert property (link_s2_reg.en && tck_rise && tap_reg == dsap_pkg::DSAP_CIR
      |=> ir_sh_reg == {prot_reg, 2'b00, $past(startup_done_in)}) else $error("bad ir pattern");
   upr_state_a: assert property (cr_wr && wb_dat_in[dsap_pkg::CR_UPR] && en_reg
      && !wb_dat_in[dsap_pkg::CR_OFF] && op_reg == dsap_pkg::DSAP_IDLE
      |=> sr_val[dsap_pkg::PORT_STATE_FIELD +: 3] == dsap_pkg::DSAP_UPR ##1 mem_req_out)
      else $error("user page read not shown");
   upr_data_a: assert property (op_reg == dsap_pkg::DSAP_UPR && mreq_reg && mem_ack_in
      && !mem_err_in && !cr_wr |=> done_reg && data_reg == $past(mem_rdata_in)
      && addr_reg == $past(addr_reg) + dsap_pkg::WORD_STEP) else $error("read word or step lost");
   page_mask_a: assert property ($rose(mem_req_out) && op_reg == dsap_pkg::DSAP_UPR
      |-> mem_addr_out - UPAGE_BASE < UPAGE_BYTES) else $error("read left user page");
   crc_force_a: assert property (cr_wr && wb_dat_in[dsap_pkg::CHECKSUM_START_CMD] && lock_reg && en_reg
      && !wb_dat_in[dsap_pkg::CR_UPR] && !wb_dat_in[dsap_pkg::CR_OFF]
      && op_reg == dsap_pkg::DSAP_IDLE |=> addr_reg == FLASH_BASE && len_reg == FLASH_BYTES
      && data_reg == dsap_pkg::CRC_INIT) else $error("protected checksum not forced");
   busy_ign_a: assert property (op_reg != dsap_pkg::DSAP_IDLE && !mem_ack_in
      && !(cr_wr && wb_dat_in[dsap_pkg::CR_OFF]) |=> op_reg == $past(op_reg))
      else $error("command taken while busy");

endmodule

`default_nettype wire

// [test/dsap_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none

// System bus slave behind the engine; answers each read after LAT cycles
module dsap_mem_model #(
   parameter int LAT = 4
) (
   // Clock and request
   input wire logic clk_in,
   input wire logic req_in,
   input wire logic [31:0] addr_in,
   // Fault injection and answer
   input wire logic err_in,
   output logic ack_out,
   output logic err_out,
   output logic [31:0] rdata_out
);
   logic ack_reg = 1'b0; // One pulse per request
   int cnt_reg = 0; // Wait cycles so far
   // Count the wait; no second pulse while the request is still being dropped
   always @(posedge clk_in) begin
      ack_reg <= req_in && !ack_reg && cnt_reg == LAT;
      cnt_reg <= (req_in && !ack_reg && cnt_reg != LAT) ? cnt_reg + 1 : 0;
   end
   assign ack_out = ack_reg;
   assign err_out = ack_reg & err_in;
   // Data is only good with the answer; inverted otherwise so nothing leans on it
   assign rdata_out = (addr_in ^ 32'h5A5A_A5A5) ^ {32{!ack_reg}};
endmodule
`default_nettype wire

// [test/dsap_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin \
   check_count++; \
   if ((g) !== (e)) begin \
      err_total++; \
      $display("ERROR %s expected %h seen %h", nm, (e), (g)); \
   end \
end

module dsap_tb_top;
   logic clk = 1'b0; // 250 MHz system clock
   logic rst_n, wbs, we, sec, erase, map_in, merr, boot_ok; // Driven levels
   logic [7:0] adr; // Register byte address
   logic [31:0] wd, rd, dout, maddr, mdata; // Bus data
   logic [3:0] pdo, poe; // Final pad drive
   logic ack, prot, map_out, mreq, mack, mfault; // Observed outputs
   dsap_pkg::dsap_link_s lk; // Test port pins
   int err_total = 0;
   int check_count = 0;

   always #2 clk = ~clk;

   // Tiny flash keeps the forced whole-array checksum short
   dsap_top #(.FLASH_BYTES(32'h0000_0010)) dsap_top_i (
      .clk_sys_in(clk), .rst_n_in(rst_n), .wb_cyc_in(wbs), .wb_stb_in(wbs),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wd),
      .wb_ack_out(ack), .wb_dat_out(dout), .port_en_in(lk.en), .tck_in(lk.tck),
      .tms_in(lk.tms), .tdi_in(lk.tdi), .mux_do_in(4'h5), .mux_oe_in(4'hD),
      .pad_do_out(pdo), .pad_oe_out(poe), .sec_bit_in(sec), .erase_done_in(erase),
      .startup_done_in(boot_ok), .prot_out(prot), .map_req_in(map_in), .map_req_out(map_out),
      .mem_req_out(mreq), .mem_addr_out(maddr), .mem_ack_in(mack), .mem_err_in(mfault),
      .mem_rdata_in(mdata));

   dsap_mem_model dsap_mem_model_i (.clk_in(clk), .req_in(mreq), .addr_in(maddr),
      .err_in(merr), .ack_out(mack), .err_out(mfault), .rdata_out(mdata));

   function automatic logic [31:0] memw(input logic [31:0] a);
      return a ^ 32'h5A5A_A5A5;
   endfunction

   // Reflected checksum, bit 0 of the word first
   function automatic logic [31:0] crc(input logic [31:0] c, input logic [31:0] w);
      for (int i = 0; i < 32; i++) c = (c >> 1) ^ ((c[0] ^ w[i]) ? 32'hEDB8_8320 : 32'h0);
      return c;
   endfunction

   task automatic give_verdict();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Classic single cycle; held until ack is sampled, then one idle cycle
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wbs <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1) begin
         err_total++;
         give_verdict();
      end
      rd = dout;
      wbs <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rst();
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask

   // Poll status until done, bounded
   task automatic wdone();
      rd = 32'h0;
      for (int n = 0; n < 200 && rd[dsap_pkg::SR_DONE] !== 1'b1; n++) begin
         wb(1'b0, dsap_pkg::OFS_SR, 32'h0);
      end
      `CHK("done", 1'b1, rd[dsap_pkg::SR_DONE])
   endtask

   task automatic crc_run(input logic [31:0] a, input logic [31:0] l, input logic [31:0] s);
      wb(1'b1, dsap_pkg::OFS_ADDR, a);
      wb(1'b1, dsap_pkg::OFS_LEN, l);
      wb(1'b1, dsap_pkg::OFS_DATA, s);
      wb(1'b1, dsap_pkg::OFS_CR, 32'h2);
   endtask

   // Protected part: access port shut, user page readable, checksum forced
   task automatic t_locked();
      logic [31:0] c;
      c = 32'hFFFF_FFFF;
      map_in <= 1'b1;
      wb(1'b0, dsap_pkg::OFS_SR, 32'h0);
      `CHK("status", 32'h0000_0308, rd)
      `CHK("map_shut", 1'b0, map_out)
      wb(1'b0, 8'h40, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      wb(1'b1, dsap_pkg::OFS_ADDR, 32'h204);
      wb(1'b1, dsap_pkg::OFS_CR, 32'h1);
      wb(1'b0, dsap_pkg::OFS_SR, 32'h0);
      `CHK("state", 3'h1, rd[6:4])
      wdone();
      wb(1'b0, dsap_pkg::OFS_DATA, 32'h0);
      `CHK("page_word", memw(dsap_pkg::UPAGE_BASE_DEF + 32'h4), rd)
      wb(1'b1, dsap_pkg::OFS_CR, 32'h1);
      wdone();
      wb(1'b0, dsap_pkg::OFS_DATA, 32'h0);
      `CHK("next_word", memw(dsap_pkg::UPAGE_BASE_DEF + 32'h8), rd)
      crc_run(32'h40, 32'h4, 32'h0);
      wdone();
      wb(1'b0, dsap_pkg::OFS_DATA, 32'h0);
      for (int i = 0; i < 16; i += 4) c = crc(c, memw(i));
      `CHK("forced_sum", c, rd)
   endtask

   // Erase opens the port at once; reported state waits for reset
   task automatic t_erase();
      erase <= 1'b1;
      @(posedge clk);
      erase <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK("map_open", 1'b1, map_out)
      `CHK("prot_kept", 1'b1, prot)
      sec <= 1'b0;
      rst();
      `CHK("prot_new", 1'b0, prot)
   endtask

   // Writes and starts during a run must not disturb it
   task automatic t_crc();
      crc_run(32'h100, 32'h8, 32'hFFFF_FFFF);
      wb(1'b1, dsap_pkg::OFS_ADDR, 32'h0);
      wb(1'b1, dsap_pkg::OFS_CR, 32'h1);
      wdone();
      `CHK("flags", 2'h0, rd[2:1])
      wb(1'b0, dsap_pkg::OFS_DATA, 32'h0);
      `CHK("sum", crc(crc(32'hFFFF_FFFF, memw(32'h100)), memw(32'h104)), rd)
      merr <= 1'b1;
      crc_run(32'h0, 32'h4, 32'h0);
      wdone();
      merr <= 1'b0;
      `CHK("bus_fault", 1'b1, rd[dsap_pkg::BUS_FAULT_FLAG])
   endtask

   // Off cancels and refuses starts until on
   task automatic t_off();
      crc_run(32'h0, 32'h40, 32'h0);
      wb(1'b1, dsap_pkg::OFS_CR, 32'h4);
      wb(1'b1, dsap_pkg::OFS_CR, 32'h2);
      wb(1'b0, dsap_pkg::OFS_SR, 32'h0);
      `CHK("off_state", 4'h0, rd[6:3])
      wb(1'b1, dsap_pkg::OFS_CR, 32'h8);
      boot_ok <= 1'b0;
      wb(1'b0, dsap_pkg::OFS_SR, 32'h0);
      `CHK("on_state", 4'h1, rd[6:3])
      `CHK("boot_low", 1'b0, rd[dsap_pkg::SR_START])
      boot_ok <= 1'b1;
   endtask

   // One test clock period of 80 ns; output sampled late in the low phase
   task automatic tbit(input logic m, input logic d, output logic o);
      lk.tms <= m;
      lk.tdi <= d;
      repeat (10) @(posedge clk);
      o = pdo[1];
      lk.tck <= 1'b1;
      repeat (10) @(posedge clk);
      lk.tck <= 1'b0;
   endtask

   // Walk to the instruction shift and read the status pattern
   task automatic t_tap();
      logic o;
      logic [9:0] walk;
      walk = 10'h0DF;
      `CHK("pad_do", 4'h5, pdo)
      `CHK("pad_oe", 4'hD, poe)
      lk.en <= 1'b1;
      for (int i = 0; i < 10; i++) tbit(walk[i], 1'b0, o);
      repeat (10) @(posedge clk);
      `CHK("pad_oe_shift", 4'h2, poe)
      for (int i = 0; i < 4; i++) begin
         tbit(i == 3, i[0], o);
         `CHK("ir_bit", 4'b0001 >> i & 4'h1, {3'h0, o})
      end
      // Through update to capture the status data word
      for (int i = 0; i < 4; i++) tbit(i < 2, 1'b0, o);
      // low bit first, 8 of 32
      // only the leading bits are judged
      for (int i = 0; i < 8; i++) begin
         tbit(i == 7, 1'b1, o);
         `CHK("dr_bit", 8'h04 >> i & 8'h01, {7'h00, o})
      end
   endtask

   initial begin
      {rst_n, wbs, we, erase, map_in, merr, lk} = '0;
      adr = 8'h00;
      wd = 32'h0;
      {sec, boot_ok} = 2'h3;
      rst();
      t_locked();
      t_erase();
      t_crc();
      t_off();
      t_tap();
      give_verdict();
   end
endmodule
`default_nettype wire
